// ==== logic/scp_defs.vh ====
// Register map, field positions and reset values of the serial port
`ifndef SCP_DEFS_VH
`define SCP_DEFS_VH
// Register indices (byte address is four times the index)
`define SCP_IDX_CR1   3'h0
`define SCP_IDX_CR2   3'h1
`define SCP_IDX_RATE  3'h2
`define SCP_IDX_FLAGS 3'h3
`define SCP_IDX_RSVA  3'h4
`define SCP_IDX_DATA  3'h5
`define SCP_IDX_RSVB  3'h6
`define SCP_IDX_RSVC  3'h7
// Primary control fields
`define SCP_XFIE 7
`define SCP_EN   6
`define SCP_TXIE 5
`define SCP_ROLE 4
`define SCP_CLOCK_IDLE_POLARITY 3
`define SCP_CLOCK_SAMPLE_PHASE 2
`define SCP_SELECT_OUTPUT_ENABLE 1
`define SCP_LSB  0
// Secondary control fields
`define SCP_FLTEN 4
`define SCP_WSTOP 1
// Flag fields
`define SCP_F_DONE 7
`define SCP_F_TXE  5
`define SCP_F_MODE_FAULT_FLAG 4
// Writable masks and reset values
`define SCP_CR2_MASK  8'h12
`define SCP_RATE_MASK 8'h77
`define SCP_CR1_RST   8'h04
`define SCP_CR2_RST   8'h00
`define SCP_RATE_RST  8'h00
// Clock edges per byte
`define SCP_EDGES 5'h10
`endif

// ==== logic/scp_sync.v ====
// Two-stage synchroniser for asynchronous pin inputs
`default_nettype none
module scp_sync #(
    parameter W = 4
) (
    input  wire         clk,
    input  wire         sys_rst,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] stage1;

    // First stage feeds only the second stage
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // scp_sync
`default_nettype wire

// ==== logic/scp_clkdiv.v ====
// Serial clock half-period tick generator
`default_nettype none
module scp_clkdiv (
    input  wire       clk,
    input  wire       sys_rst,
    input  wire       run,
    input  wire [2:0] pre,
    input  wire [2:0] sel,
    output wire       tick
);
    reg  [10:0] cnt;
    wire [10:0] half;

    // Half period is (pre+1) * 2^sel bus clocks
    assign half = ({7'h00, pre} + 11'h001) << sel;
    assign tick = run & (cnt == half - 11'h001);

    // Counter restarts whenever generation is off
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 11'h000;
        end else if (!run || tick) begin
            cnt <= 11'h000;
        end else begin
            cnt <= cnt + 11'h001;
        end
    end
endmodule // scp_clkdiv
`default_nettype wire

// ==== logic/scp_core.v ====
// Serial peripheral port with APB registers, master and slave roles
//
// Contract
// - Wait with clock-stop clear runs normally
// - Wait with clock-stop set freezes master
// - Stop mode freezes master, resumes afterwards
// - Slave keeps shifting through wait and stop
// - MOSI drives as master, samples as slave
// - MISO drives as slave, samples as master
// - Select pin output as master with secondary bit 4 and primary bit 1 set, input slave
// - Master drives SCK; slave follows SCK
// - Reserved bits and slots read zero
// - Flag register ignores all writes
// - Primary control readable and writable always
// - Bit 7 enables done and fault interrupt
// - Bit 6 enables port; clear idles, resets flags
// - Bit 5 enables transmit-empty interrupt
// - Bit 4 selects role; change forces idle
// - Bit 3 sets clock idle level
// - Bit 2 picks odd or even sample edges
// - Master format changes abort transfer
// - Bit 0 selects low bit first
// - Select pin use per role and enables
// - Secondary bit 1 is wait clock stop
// - Secondary bit 4 enables fault detection
//
// Implementation choice: the APB slave port.
`default_nettype none
`include "scp_defs.vh"
module scp_core (
    input  wire        clk,
    input  wire        sys_rst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [4:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    input  wire        waitMode,
    input  wire        stopMode,
    input  wire        sckIn,
    input  wire        ssIn,
    input  wire        mosiIn,
    input  wire        misoIn,
    output reg         sckOut,
    output reg         sckOe,
    output reg         ssOut,
    output reg         select_output_enable,
    output reg         mosiOut,
    output reg         mosiOe,
    output reg         misoOut,
    output reg         misoOe,
    output reg         irq
);
    // Software state
    reg  [7:0]  cr1;
    reg  [7:0]  cr2;
    reg  [7:0]  rate;
    reg  [7:0]  txBuf;
    reg         txFull;
    reg  [7:0]  rxData;
    reg         doneFlag;
    reg         modfFlag;
    // Engine state
    reg         active;
    reg  [4:0]  edgeCnt;
    reg  [7:0]  sh;
    reg         sckLvl;
    reg         dataOut;
    reg         sckPrev;
    reg         activeLate;
    // Synchronised pins
    wire [3:0]  pinSync;
    wire        sckS;
    wire        ssS;
    wire        mosiS;
    wire        misoS;
    // Bus decode
    wire        acc;
    wire        wrEn;
    wire        rdEn;
    wire [2:0]  idx;
    wire        wCr1;
    wire        wCr2;
    wire        wRate;
    wire        wData;
    wire        rData;
    reg  [7:0]  rdMux;
    // Control decode
    wire        en;
    wire        master;
    wire        clock_idle_polarity;
    wire        clock_sample_phase;
    wire        lsb;
    wire        frozen;
    wire        modfEvt;
    wire        roleChg;
    wire        fmtChg;
    wire        cr2Chg;
    wire        rateChg;
    wire        desel;
    wire        abort;
    wire        tick;
    wire        sckEdge;
    wire        ev;
    wire [4:0]  nEdge;
    wire        smp;
    wire        last;
    wire        inBit;
    wire        head;
    wire        loadHead;
    wire [7:0]  shifted;
    wire        startReq;

    // Pins cross into the bus clock through two flops
    scp_sync #(
        .W (4)
    ) uSync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .din     ({sckIn, ssIn, mosiIn, misoIn}),
        .dout    (pinSync)
    );
    assign sckS  = pinSync[3];
    assign ssS   = pinSync[2];
    assign mosiS = pinSync[1];
    assign misoS = pinSync[0];

    // APB decode; answer comes in the second access cycle
    assign acc   = psel & penable;
    assign wrEn  = acc & pready & pwrite;
    assign rdEn  = acc & pready & ~pwrite;
    assign idx   = paddr[4:2];
    assign wCr1  = wrEn & (idx == `SCP_IDX_CR1);
    assign wCr2  = wrEn & (idx == `SCP_IDX_CR2);
    assign wRate = wrEn & (idx == `SCP_IDX_RATE);
    assign wData = wrEn & (idx == `SCP_IDX_DATA);
    assign rData = rdEn & (idx == `SCP_IDX_DATA);

    // Control fields
    assign en     = cr1[`SCP_EN];
    assign master = cr1[`SCP_ROLE];
    assign clock_idle_polarity   = cr1[`SCP_CLOCK_IDLE_POLARITY];
    assign clock_sample_phase   = cr1[`SCP_CLOCK_SAMPLE_PHASE];
    assign lsb    = cr1[`SCP_LSB];

    // Master clock halts in stop, and in wait when clock-stop is set
    assign frozen = master & (stopMode | (waitMode & cr2[`SCP_WSTOP]));

    // Select low while used as fault input drops master
    assign modfEvt = en & master & cr2[`SCP_FLTEN] & ~cr1[`SCP_SELECT_OUTPUT_ENABLE] & ~ssS;

    // Configuration changes that end a transfer
    assign roleChg = wCr1 & (pwdata[`SCP_ROLE] != master);
    assign fmtChg  = wCr1 & (pwdata[3:0] != cr1[3:0]);
    assign cr2Chg  = wCr2 & (pwdata[`SCP_FLTEN] != cr2[`SCP_FLTEN]);
    assign rateChg = wRate & ((pwdata[7:0] & `SCP_RATE_MASK) != rate);
    assign desel   = ~master & ssS & active;
    assign abort   = ~en | roleChg | modfEvt | desel
                   | (master & (fmtChg | cr2Chg | rateChg));

    // Master bit clock, gated while frozen
    scp_clkdiv uDiv (
        .clk     (clk),
        .sys_rst (sys_rst),
        .run     (en & master & active & ~frozen),
        .pre     (rate[6:4]),
        .sel     (rate[2:0]),
        .tick    (tick)
    );

    // Edge source: own divider as master, pin clock as slave
    assign sckEdge = sckS ^ sckPrev;
    assign ev      = active & ~abort & (master ? tick : (sckEdge & ~ssS));
    assign nEdge   = edgeCnt + 5'h01;
    assign smp     = clock_sample_phase ? ~nEdge[0] : nEdge[0];
    assign last    = (nEdge == `SCP_EDGES);

    // Receive pin depends on role
    assign inBit   = master ? misoS : mosiS;
    assign head    = lsb ? sh[0] : sh[7];
    assign loadHead = lsb ? txBuf[0] : txBuf[7];
    assign shifted = lsb ? {inBit, sh[7:1]} : {sh[6:0], inBit};

    // Master starts on a queued byte, slave on select low
    assign startReq = en & ~active & ~abort & (master ? (txFull & ~frozen) : ~ssS);

    // Register read multiplexer
    always @* begin
        case (idx)
            `SCP_IDX_CR1:   rdMux = cr1;
            `SCP_IDX_CR2:   rdMux = cr2;
            `SCP_IDX_RATE:  rdMux = rate;
            `SCP_IDX_FLAGS: rdMux = {doneFlag, 1'b0, ~txFull, modfFlag, 4'h0};
            `SCP_IDX_DATA:  rdMux = rxData;
            default:        rdMux = 8'h00;
        endcase
    end

    // APB answer and read data
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= acc & ~pready;
            if (acc && !pready) begin
                prdata <= {24'h000000, rdMux};
            end
        end
    end

    // Control registers; flag slot has no write path
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            cr1  <= `SCP_CR1_RST;
            cr2  <= `SCP_CR2_RST;
            rate <= `SCP_RATE_RST;
        end else begin
            if (wCr1) begin
                cr1 <= pwdata[7:0];
            end
            if (wCr2) begin
                cr2 <= pwdata[7:0] & `SCP_CR2_MASK;
            end
            if (wRate) begin
                rate <= pwdata[7:0] & `SCP_RATE_MASK;
            end
            if (modfEvt) begin
                cr1[`SCP_ROLE] <= 1'b0;
            end
        end
    end

    // Status flags; hardware set wins over software clear
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            doneFlag <= 1'b0;
            modfFlag <= 1'b0;
        end else if (!en) begin
            doneFlag <= 1'b0;
            modfFlag <= 1'b0;
        end else begin
            if (ev && last) begin
                doneFlag <= 1'b1;
            end else if (rData) begin
                doneFlag <= 1'b0;
            end
            if (modfEvt) begin
                modfFlag <= 1'b1;
            end else if (wCr1) begin
                modfFlag <= 1'b0;
            end
        end
    end

    // Transmit buffer; a write while full is dropped
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            txBuf  <= 8'h00;
            txFull <= 1'b0;
        end else if (!en) begin
            txFull <= 1'b0;
        end else if (startReq) begin
            txFull <= 1'b0;
        end else if (wData && !txFull) begin
            txBuf  <= pwdata[7:0];
            txFull <= 1'b1;
        end
    end

    // Shift engine shared by both roles
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            active  <= 1'b0;
            edgeCnt <= 5'h00;
            sh      <= 8'h00;
            sckLvl  <= 1'b0;
            dataOut <= 1'b0;
            rxData  <= 8'h00;
            sckPrev <= 1'b0;
        end else begin
            sckPrev <= sckS;
            if (abort) begin
                active  <= 1'b0;
                edgeCnt <= 5'h00;
                sckLvl  <= clock_idle_polarity;
            end else if (startReq) begin
                active  <= 1'b1;
                edgeCnt <= 5'h00;
                sh      <= txBuf;
                dataOut <= loadHead;
                sckLvl  <= clock_idle_polarity;
            end else if (ev) begin
                edgeCnt <= nEdge;
                if (master) begin
                    sckLvl <= ~sckLvl;
                end
                if (smp) begin
                    sh <= shifted;
                end else begin
                    dataOut <= head;
                end
                if (last) begin
                    active  <= 1'b0;
                    edgeCnt <= 5'h00;
                    rxData  <= smp ? shifted : sh;
                end
            end else if (!active) begin
                sckLvl <= clock_idle_polarity;
            end
        end
    end

    // Registered pin drivers and interrupt request
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sckOut  <= 1'b0;
            sckOe   <= 1'b0;
            ssOut   <= 1'b1;
            activeLate <= 1'b0;
            select_output_enable    <= 1'b0;
            mosiOut <= 1'b0;
            mosiOe  <= 1'b0;
            misoOut <= 1'b0;
            misoOe  <= 1'b0;
            irq     <= 1'b0;
        end else begin
            sckOut  <= (master & active) ? sckLvl : clock_idle_polarity;
            sckOe   <= en & master;
            mosiOut <= dataOut;
            mosiOe  <= en & master;
            misoOut <= dataOut;
            misoOe  <= en & ~master & ~ssS;
            // Select stays low one clock past the last clock edge
            activeLate <= active;
            ssOut   <= ~(active | activeLate);
            select_output_enable    <= en & master & cr2[`SCP_FLTEN] & cr1[`SCP_SELECT_OUTPUT_ENABLE];
            irq     <= (cr1[`SCP_XFIE] & (doneFlag | modfFlag))
                     | (cr1[`SCP_TXIE] & ~txFull);
        end
    end
endmodule // scp_core
`default_nettype wire

// ==== dv/scp_core_monitor.sv ====
// Pin and bus checks bound to the serial port core
`default_nettype none
module scp_core_monitor (
    input wire logic        clk,
    input wire logic        sys_rst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [4:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        stopMode,
    input wire logic        ssIn,
    input wire logic        sckOut,
    input wire logic        sckOe,
    input wire logic        select_output_enable,
    input wire logic        mosiOut,
    input wire logic        mosiOe,
    input wire logic        misoOe,
    input wire logic        irq
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] ssHigh;
    wire        acc = psel && penable && pready;
    wire        cr1Wr = acc && pwrite && paddr[4:2] == 3'h0;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);
    // Cycles the select input has stayed high
    always_ff @(posedge clk or posedge sys_rst)
        if (sys_rst)
            ssHigh <= 3'h0;
        else if (!ssIn)
            ssHigh <= 3'h0;
        else if (ssHigh != 3'h7)
            ssHigh <= ssHigh + 3'h1;
    chk_ready_timing: assert property (psel && !penable |-> ##2 pready)
        else $error("pready late");
    chk_rsvd_zero: assert property (acc && !pwrite && paddr[4:2] inside {3'h4, 3'h6, 3'h7} |-> prdata == 32'h0)
        else $error("reserved read not zero");
    chk_pin_roles: assert property (!(mosiOe && misoOe))
        else $error("both data pins driven");
    chk_select_out: assert property (select_output_enable |-> sckOe && !misoOe)
        else $error("select driven outside master");
    chk_slave_release: assert property (ssHigh >= 3'h5 |-> !misoOe)
        else $error("slave drives while deselected");
    chk_stop_freeze: assert property ((sckOe && stopMode) [*4] |-> $stable(sckOut) && $stable(mosiOut))
        else $error("pins move in stop");
    chk_disable_idle: assert property (cr1Wr && !pwdata[6] |-> ##2 !(sckOe || mosiOe || misoOe || select_output_enable))
        else $error("pins driven while disabled");
    chk_irq_off: assert property (cr1Wr && !pwdata[7] && !pwdata[5] |-> ##2 !irq)
        else $error("irq with enables clear");
endmodule // scp_core_monitor
bind scp_core scp_core_monitor scp_core_monitor_inst (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .stopMode(stopMode), .ssIn(ssIn), .sckOut(sckOut),
    .sckOe(sckOe), .select_output_enable(select_output_enable), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoOe(misoOe), .irq(irq)
);
`default_nettype wire

// ==== dv/scp_peer.sv ====
// Remote serial device answering the core when it is master
`default_nettype none
module scp_peer (
    input  wire logic       sck,
    input  wire logic       selN,
    input  wire logic       mosi,
    input  wire logic       clock_idle_polarity,
    input  wire logic       clock_sample_phase,
    input  wire logic [7:0] txByte,
    output var  logic       miso,
    output var  logic [7:0] rxByte
);
    timeunit 1ns;
    timeprecision 1ps;
    int idx;
    initial miso = 1'b0;
    // Selection starts a byte, phase 0 shows the first bit at once
    always @(negedge selN) begin
        idx = 0;
        miso = clock_sample_phase ? ~miso : txByte[7];
    end
    // A released line does not keep its last level
    always @(posedge selN)
        miso = ~miso;
    // Sample on one edge kind, launch on the other
    always @(sck) begin
        if (selN === 1'b0) begin
            if (sck === (clock_idle_polarity ~^ clock_sample_phase))
                rxByte = {rxByte[6:0], mosi};
            else begin
                miso = txByte[(clock_sample_phase ? 7 - idx : 6 - idx) & 7];
                idx = idx + 1;
            end
        end
    end
endmodule // scp_peer
`default_nettype wire

// ==== dv/scp_core_tb.sv ====
// Self-checking bench for the serial port core
`default_nettype none
module scp_core_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, sys_rst, psel, penable, pwrite, waitMode, stopMode;
    logic        sckDrv, ssDrv, mosiDrv, pready, sckOut, sckOe, ssOut, select_output_enable;
    logic        mosiOut, mosiOe, misoOut, misoOe, irq, peerMiso;
    logic [4:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0]  cfg, tx, sl, got, peerTx, peerRx;
    int          err_count, comparisons;
    wire         ssLine = select_output_enable ? ssOut : ssDrv;
    scp_core scp_core_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .waitMode(waitMode),
        .stopMode(stopMode), .sckIn(sckDrv), .ssIn(ssLine), .mosiIn(mosiDrv), .misoIn(peerMiso),
        .sckOut(sckOut), .sckOe(sckOe), .ssOut(ssOut), .select_output_enable(select_output_enable), .mosiOut(mosiOut), .mosiOe(mosiOe),
        .misoOut(misoOut), .misoOe(misoOe), .irq(irq));
    scp_peer scp_peer_inst (.sck(sckOut), .selN(ssLine), .mosi(mosiOut), .clock_idle_polarity(cfg[3]), .clock_sample_phase(cfg[2]),
        .txByte(peerTx), .miso(peerMiso), .rxByte(peerRx));
    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++)
            rev8[i] = b[7 - i];
    endfunction
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // One APB transfer, held until pready is seen
    task automatic apb(input logic wr, input logic [2:0] idx, input logic [7:0] wd);
        int n;
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, idx, 2'h0, 24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n >= 20)
            err_count++;
        rd = prdata;
        {psel, penable} <= 2'h0;
    endtask
    task automatic rdx(input logic [2:0] idx, input logic [31:0] e);
        apb(1'b0, idx, 8'h00);
        chk(rd, e);
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d err_count=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // Bus clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard
    initial begin
        #1000000;
        err_count++;
        report_and_stop;
    end
    // Main sequence
    initial begin
        {psel, penable, pwrite, waitMode, stopMode, sckDrv, mosiDrv, paddr, pwdata, cfg, peerTx} = 60'h0;
        {ssDrv, sys_rst} = 2'h3;
        void'($urandom(32'h67d09a74));
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        rdx(3'h0, 32'h04);
        rdx(3'h1, 32'h00);
        rdx(3'h2, 32'h00);
        apb(1'b1, 3'h3, 8'hFF);
        rdx(3'h3, 32'h20);
        foreach (cfg[i]) if (i inside {4, 6, 7}) begin
            apb(1'b1, 3'(i), 8'hFF);
            rdx(3'(i), 32'h0);
        end
        apb(1'b1, 3'h1, 8'hFF);
        rdx(3'h1, 32'h12);
        apb(1'b1, 3'h2, 8'hFF);
        rdx(3'h2, 32'h77);
        tx = 8'($urandom) & 8'hBF;
        apb(1'b1, 3'h0, tx);
        rdx(3'h0, {24'h0, tx});
        $display("registers done");
        apb(1'b1, 3'h2, 8'h12);
        for (int m = 0; m < 8; m++) begin
            cfg = {4'h5, m[2], m[1], 1'b1, m[0]};
            apb(1'b1, 3'h1, m == 4 ? 8'h10 : 8'h12);
            apb(1'b1, 3'h0, cfg);
            repeat (2) @(posedge clk);
            chk(32'(sckOut), 32'(cfg[3]));
            peerTx = 8'($urandom);
            tx = 8'($urandom);
            apb(1'b1, 3'h5, tx);
            // Let the byte get under way so the freeze lands mid-transfer
            repeat (40) @(posedge clk);
            waitMode <= (m == 2 || m == 4);
            stopMode <= (m == 3);
            repeat (200) @(posedge clk);
            apb(1'b0, 3'h3, 8'h00);
            chk(32'(rd[7]), (m == 2 || m == 3) ? 32'h0 : 32'h1);
            {waitMode, stopMode} <= 2'h0;
            for (int n = 0; n < 400 && rd[7] !== 1'b1; n++)
                apb(1'b0, 3'h3, 8'h00);
            rdx(3'h5, 32'(m[0] ? rev8(peerTx) : peerTx));
            chk(32'(peerRx), 32'(m[0] ? rev8(tx) : tx));
        end
        $display("master modes done");
        apb(1'b1, 3'h0, 8'hD0);
        ssDrv <= 1'b0;
        repeat (6) @(posedge clk);
        ssDrv <= 1'b1;
        rdx(3'h3, 32'h30);
        rdx(3'h0, 32'hC0);
        chk(32'(irq), 32'h1);
        apb(1'b1, 3'h0, 8'h20);
        rdx(3'h3, 32'h20);
        chk(32'(irq), 32'h1);
        apb(1'b1, 3'h0, 8'h00);
        repeat (2) @(posedge clk);
        chk(32'(irq), 32'h0);
        $display("mode fault done");
        apb(1'b1, 3'h0, 8'h40);
        tx = 8'($urandom);
        sl = 8'($urandom);
        apb(1'b1, 3'h5, tx);
        {stopMode, ssDrv} <= 2'h2;
        repeat (8) @(posedge clk);
        for (int b = 7; b >= 0; b--) begin
            mosiDrv <= sl[b];
            repeat (4) @(posedge clk);
            sckDrv <= 1'b1;
            @(posedge clk);
            got[b] = misoOut;
            repeat (3) @(posedge clk);
            sckDrv <= 1'b0;
        end
        repeat (4) @(posedge clk);
        {stopMode, ssDrv} <= 2'h1;
        chk(32'(got), 32'(tx));
        rdx(3'h5, 32'(sl));
        $display("slave done");
        report_and_stop;
    end
endmodule // scp_core_tb
`default_nettype wire
